// [verilog/sat_cfg_consts.vh]
`ifndef SAT_CFG_CONSTS_VH
`define SAT_CFG_CONSTS_VH
// command word layout
`define CMD_PARITY_BIT 15
`define CMD_SELECT_BIT 14
`define CMD_WORD_BITS 16
`define CMD_WORDS_PER_FRAME 4
// global register fields
`define GLB_WIDTH 14
`define GLB_RESET 14'h0000
`define GLB_HALL_LO 4
`define GLB_HALL_HI 7
`define GLB_PROTO_LO 8
`define GLB_PROTO_HI 11
`define GLB_PSENSE_BIT 12
// per-channel register fields
`define CH_WIDTH 14
`define CH_RESET 14'h0000
`define CH_FLUSH_BIT 13
`define CH_MASKSEL_BIT 12
`define CH_MASK_LOW 14'h33FF
`define CH_MASK_HIGH 14'h3C30
`define CH_REPLY_LO 10
`define CH_BITTIME_LO 8
`define CH_DLEN_LO 6
`define CH_SUPPLY_LO 4
`define CH_HYST_BIT 3
`define CH_THRESH_LO 0
// answer to a misplaced global write
`define REPLY_REJECT 16'hE000
// deglitch filter length in clock cycles
`define DEGLITCH_CYCLES 4
`endif

// [verilog/satellite_channel_config_regs.v]
// Summary of operation
// - global bits 7:4 put channels 3/4 into hall mode, off after reset
// - global bits 11:8 choose plain or parity-checked variant per channel
// - parity mismatch on a parity-variant channel's sensor message raises a parity error report
// - parity-sense write ignored while no channel uses the parity variant
// - global bit 12 picks even/odd parity; plain channels ignore it
// - channel bit 13 set flushes that channel's message fifo
// - channel bit 12 masks which bits a channel write updates
// - channel bits 11:10 hold the reply-mode selector
// - channel bits 9:8 hold the bit-time range selector
// - channel bits 7:6 only act when channel uses the parity variant
// - bits 7:6 give data length 8,9,10 or 11 bits
// - channel bit 3 enables threshold hysteresis, off by default
// - channel bits 2:0 select the current threshold code
// - each satellite input is deglitched before the decoder
// - bits 5:4 control supply and decoder: 00 off,01 sat,10 both,11 off
// - 16-bit odd-parity words, bit 14 selects register, four per frame
// - global write honoured only as first word; else reply E000
`timescale 1ns/1ps
`include "sat_cfg_consts.vh"
module satellite_channel_config_regs #(
   parameter nchan = 4,
   parameter deglitch = `DEGLITCH_CYCLES
) (
   // clock and reset
   input wire clock,
   input wire resetn,
   // serial command port
   input wire cs_n,
   input wire sclk,
   input wire mosi,
   output reg miso,
   // satellite inputs, one per channel, raw comparator level
   input wire [nchan-1:0] sat_in,
   // received sensor message parity check inputs
   input wire [nchan-1:0] msg_done,
   input wire [nchan-1:0] msg_parity_calc,
   input wire [nchan-1:0] msg_parity_rx,
   // channel control outputs
   output reg [nchan-1:0] sat_supply_on,
   output reg [nchan-1:0] decoder_on,
   output reg [nchan-1:0] parity_variant,
   output reg parity_odd,
   output reg [2*nchan-1:0] data_len,
   output reg [2*nchan-1:0] bit_time,
   output reg [2*nchan-1:0] reply_mode,
   output reg [nchan-1:0] hyst_on,
   output reg [3*nchan-1:0] thresh,
   output reg [nchan-1:0] fifo_flush,
   output reg [nchan-1:0] parity_error,
   output reg [nchan-1:0] sat_filtered,
   output reg chan3_sense_output,
   output reg chan4_sense_output,
   output reg cmd_error
);
   // synchronisers
   reg [2:0] cs_s_r;
   reg [2:0] sclk_s_r;
   reg [1:0] mosi_s_r;
   always @(posedge clock) begin
      if (!resetn) begin
         cs_s_r <= 3'h7;
         sclk_s_r <= 3'h0;
         mosi_s_r <= 2'h0;
      end else begin
         cs_s_r <= {cs_s_r[1:0], cs_n};
         sclk_s_r <= {sclk_s_r[1:0], sclk};
         mosi_s_r <= {mosi_s_r[0], mosi};
      end
   end
   wire cs_act = ~cs_s_r[1];
   wire cs_fall = cs_s_r[2] & ~cs_s_r[1];
   wire sclk_rise = ~sclk_s_r[2] & sclk_s_r[1];
   wire sclk_fall = sclk_s_r[2] & ~sclk_s_r[1];

   // registers
   reg [`GLB_WIDTH-1:0] glb_r;
   reg [`CH_WIDTH-1:0] ch_r [0:nchan-1];
   reg [`CMD_WORD_BITS-1:0] shift_r;
   reg [3:0] bitcnt_r;
   reg [2:0] word_r;
   reg [`CMD_WORD_BITS-1:0] reply_r [0:nchan-1];
   reg [`CMD_WORD_BITS-1:0] txsh_r;
   reg [`CMD_WORD_BITS-1:0] rx_word;
   reg word_done;
   always @* begin
      rx_word = {shift_r[`CMD_WORD_BITS-2:0], mosi_s_r[1]};
      word_done = cs_act & sclk_rise & (bitcnt_r == 4'hF);
   end
   wire cmd_par_ok = ^rx_word;
   wire cmd_chan_sel = rx_word[`CMD_SELECT_BIT];
   wire [1:0] widx = word_r[1:0];
   wire any_b = |glb_r[`GLB_PROTO_HI:`GLB_PROTO_LO];
   wire [`CH_WIDTH-1:0] cur_ch = ch_r[widx];
   wire [`CH_WIDTH-1:0] wmask = rx_word[`CH_MASKSEL_BIT] ? `CH_MASK_HIGH : `CH_MASK_LOW;
   wire [`CH_WIDTH-1:0] ch_wr_val = (cur_ch & ~wmask) | (rx_word[`CH_WIDTH-1:0] & wmask);
   wire [1:0] rx_mode = rx_word[`CH_REPLY_LO+1:`CH_REPLY_LO];
   wire glb_ok = (word_r == 3'h0);

   // global value with parity-sense bit held when no channel uses parity
   reg [`GLB_WIDTH-1:0] glb_wr_val;
   always @* begin
      glb_wr_val = rx_word[`GLB_WIDTH-1:0];
      if (!any_b) begin
         glb_wr_val[`GLB_PSENSE_BIT] = glb_r[`GLB_PSENSE_BIT];
      end
   end

   // command decode and configuration writes
   integer k;
   always @(posedge clock) begin
      if (!resetn) begin
         glb_r <= `GLB_RESET;
         shift_r <= 16'h0000;
         bitcnt_r <= 4'h0;
         word_r <= 3'h0;
         cmd_error <= 1'b0;
         fifo_flush <= {nchan{1'b0}};
         for (k = 0; k < nchan; k = k + 1) begin
            ch_r[k] <= `CH_RESET;
            reply_r[k] <= 16'h0000;
         end
      end else begin
         fifo_flush <= {nchan{1'b0}};
         if (cs_fall) begin
            bitcnt_r <= 4'h0;
            word_r <= 3'h0;
            cmd_error <= 1'b0;
         end else if (cs_act && sclk_rise) begin
            shift_r <= rx_word;
            bitcnt_r <= bitcnt_r + 4'h1;
         end
         if (word_done && word_r < `CMD_WORDS_PER_FRAME) begin
            word_r <= word_r + 3'h1;
            if (!cmd_par_ok) begin
               cmd_error <= 1'b1;
            end else if (!cmd_chan_sel) begin
               if (glb_ok) begin
                  glb_r <= glb_wr_val;
                  reply_r[widx] <= {2'b11, 1'b0, glb_wr_val[12:0]};
               end else begin
                  reply_r[widx] <= `REPLY_REJECT;
               end
            end else begin
               ch_r[widx] <= ch_wr_val & ~(14'h1 << `CH_FLUSH_BIT);
               fifo_flush[widx] <= rx_word[`CH_FLUSH_BIT];
               if (rx_mode == 2'b01 && widx != 2'd0)
                  reply_r[widx] <= `REPLY_REJECT;
               else if (rx_mode == 2'b01)
                  reply_r[widx] <= {2'b11, 1'b0, glb_r[12:0]};
               else
                  reply_r[widx] <= {2'b11, 1'b0, ch_wr_val[12:0]};
            end
         end
      end
   end

   // reply shifter: word loaded at frame start and every 16 bits
   always @(posedge clock) begin
      if (!resetn) begin
         txsh_r <= 16'h0000;
         miso <= 1'b0;
      end else begin
         if (cs_fall) begin
            txsh_r <= reply_r[0];
         end else if (cs_act && sclk_fall) begin
            if (bitcnt_r == 4'h0)
               txsh_r <= reply_r[word_r[1:0]];
            else
               txsh_r <= {txsh_r[14:0], 1'b0};
         end
         miso <= cs_act ? txsh_r[15] : 1'b0;
      end
   end

   // per-channel outputs, filter and parity check
   genvar g;
   generate
      for (g = 0; g < nchan; g = g + 1) begin : chan
         reg [1:0] sync_r;
         reg [3:0] cnt_r;
         wire [1:0] sd = ch_r[g][`CH_SUPPLY_LO+1:`CH_SUPPLY_LO];
         always @(posedge clock) begin
            if (!resetn) begin
               sync_r <= 2'b00;
               cnt_r <= 4'h0;
               sat_filtered[g] <= 1'b0;
               parity_error[g] <= 1'b0;
               sat_supply_on[g] <= 1'b0;
               decoder_on[g] <= 1'b0;
               parity_variant[g] <= 1'b0;
               data_len[2*g+1:2*g] <= 2'b00;
               bit_time[2*g+1:2*g] <= 2'b00;
               reply_mode[2*g+1:2*g] <= 2'b00;
               hyst_on[g] <= 1'b0;
               thresh[3*g+2:3*g] <= 3'b000;
            end else begin
               sync_r <= {sync_r[0], sat_in[g]};
               if (sync_r[1] == sat_filtered[g]) begin
                  cnt_r <= 4'h0;
               end else if (cnt_r == deglitch - 1) begin
                  cnt_r <= 4'h0;
                  sat_filtered[g] <= sync_r[1];
               end else begin
                  cnt_r <= cnt_r + 4'h1;
               end
               parity_error[g] <= msg_done[g] & parity_variant[g]
                  & ((msg_parity_calc[g] ^ parity_odd) != msg_parity_rx[g]);
               sat_supply_on[g] <= (sd == 2'b01) | (sd == 2'b10);
               decoder_on[g] <= (sd == 2'b10);
               parity_variant[g] <= glb_r[`GLB_PROTO_LO+g];
               data_len[2*g+1:2*g] <= glb_r[`GLB_PROTO_LO+g] ?
                  ch_r[g][`CH_DLEN_LO+1:`CH_DLEN_LO] : 2'b00;
               bit_time[2*g+1:2*g] <= ch_r[g][`CH_BITTIME_LO+1:`CH_BITTIME_LO];
               reply_mode[2*g+1:2*g] <= ch_r[g][`CH_REPLY_LO+1:`CH_REPLY_LO];
               hyst_on[g] <= ch_r[g][`CH_HYST_BIT];
               thresh[3*g+2:3*g] <= ch_r[g][`CH_THRESH_LO+2:`CH_THRESH_LO];
            end
         end
      end
   endgenerate

   // global outputs and hall-mode sense pins
   always @(posedge clock) begin
      if (!resetn) begin
         parity_odd <= 1'b0;
         chan3_sense_output <= 1'b0;
         chan4_sense_output <= 1'b0;
      end else begin
         parity_odd <= glb_r[`GLB_PSENSE_BIT];
         chan3_sense_output <= glb_r[`GLB_HALL_LO] ? sat_filtered[2] :
            (glb_r[`GLB_HALL_LO+2] & ~sat_filtered[2]);
         chan4_sense_output <= glb_r[`GLB_HALL_LO+1] ? sat_filtered[3] :
            (glb_r[`GLB_HALL_LO+3] & ~sat_filtered[3]);
      end
   end
endmodule // satellite_channel_config_regs

// [sim/sat_cfg_properties.sv]
`timescale 1ns/1ps
module sat_cfg_properties #(parameter nchan = 4) (
   // clock and reset
   input wire clock,
   input wire resetn,
   // watched ports
   input wire cs_n,
   input wire miso,
   input wire [nchan-1:0] msg_done,
   input wire [nchan-1:0] sat_supply_on,
   input wire [nchan-1:0] decoder_on,
   input wire [nchan-1:0] parity_variant,
   input wire parity_odd,
   input wire [2*nchan-1:0] data_len,
   input wire [3*nchan-1:0] thresh,
   input wire [nchan-1:0] fifo_flush,
   input wire [nchan-1:0] parity_error,
   input wire cmd_error
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   decoder_needs_supply_a: assert property ((decoder_on & ~sat_supply_on) == 0)
      else $error("decoder on without supply");
   plain_dlen_zero_a: assert property (!parity_variant[1] |-> data_len[3:2] == 2'b00)
      else $error("data length set on plain channel");
   flush_single_a: assert property (|fifo_flush |=> !(|fifo_flush))
      else $error("flush pulse too long");
   perror_cause_a: assert property ((parity_error & ~($past(msg_done) & $past(parity_variant))) == 0)
      else $error("parity error without message");
   psense_guard_a: assert property ($changed(parity_odd) |-> |$past(parity_variant))
      else $error("parity sense changed with no parity channel");
   miso_idle_a: assert property (cs_n [*4] |-> !miso)
      else $error("reply line active outside frame");
   cmd_error_clear_a: assert property ($fell(cs_n) |-> ##[1:6] !cmd_error)
      else $error("command error not cleared");
   config_quiet_a: assert property (cs_n [*8] |-> $stable(thresh))
      else $error("threshold changed outside frame");
   reset_defaults_a: assert property ($rose(resetn) |-> !(|{sat_supply_on, decoder_on, parity_variant, thresh}))
      else $error("fields not at defaults after reset");
endmodule // sat_cfg_properties
bind satellite_channel_config_regs sat_cfg_properties #(.nchan(nchan)) props_u (
   .clock(clock), .resetn(resetn), .cs_n(cs_n), .miso(miso), .msg_done(msg_done),
   .sat_supply_on(sat_supply_on), .decoder_on(decoder_on), .parity_variant(parity_variant),
   .parity_odd(parity_odd), .data_len(data_len), .thresh(thresh), .fifo_flush(fifo_flush),
   .parity_error(parity_error), .cmd_error(cmd_error));

// [sim/spi_host_model.sv]
`timescale 1ns/1ps
module spi_host_model (
   // clock
   input wire clock,
   // serial lines
   output reg cs_n,
   output reg sclk,
   output reg mosi,
   input wire miso
);
   reg [63:0] rx_r;
   integer i;
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
      rx_r = 64'h0;
   end
   // four words, first word for channel one; bad flags spoil parity
   task frame(input [63:0] w, input [3:0] bad);
      reg [63:0] s;
      begin
         s = w;
         for (i = 0; i < 4; i = i + 1)
            s[16*i+15] = ~^s[16*i+:15] ^ bad[i];
         @(posedge clock);
         cs_n <= 1'b0;
         repeat (8) @(posedge clock);
         for (i = 63; i >= 0; i = i - 1) begin
            mosi <= s[i];
            repeat (8) @(posedge clock);
            sclk <= 1'b1;
            rx_r[i] <= miso;
            repeat (8) @(posedge clock);
            sclk <= 1'b0;
         end
         repeat (8) @(posedge clock);
         cs_n <= 1'b1;
         mosi <= ~mosi;
         repeat (16) @(posedge clock);
      end
   endtask
endmodule // spi_host_model

// [sim/testbench.sv]
`timescale 1ns/1ps
`define check(nm, e, g) begin n_tests = n_tests + 1; if ((g) !== (e)) begin \
   num_errors = num_errors + 1; $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module testbench;
   reg clock, resetn;
   reg [3:0] sat_in, msg_done, msg_rx, msg_calc, flush_seen, perr_seen;
   wire cs_n, sclk, mosi, miso, podd, s3, s4, cerr;
   wire [3:0] sup, dec, pvar, hyst, flush, perr, sfil;
   wire [7:0] dlen, btime, rmode;
   wire [11:0] thr;
   integer num_errors, n_tests;
   satellite_channel_config_regs dut_u (.clock(clock), .resetn(resetn), .cs_n(cs_n),
      .sclk(sclk), .mosi(mosi), .miso(miso), .sat_in(sat_in), .msg_done(msg_done),
      .msg_parity_calc(msg_calc), .msg_parity_rx(msg_rx), .sat_supply_on(sup), .decoder_on(dec),
      .parity_variant(pvar), .parity_odd(podd), .data_len(dlen), .bit_time(btime),
      .reply_mode(rmode), .hyst_on(hyst), .thresh(thr), .fifo_flush(flush),
      .parity_error(perr), .sat_filtered(sfil), .chan3_sense_output(s3),
      .chan4_sense_output(s4), .cmd_error(cerr));
   spi_host_model host_u (.clock(clock), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso));
   always @(posedge clock) begin
      if (!resetn) begin
         flush_seen <= 4'h0;
         perr_seen <= 4'h0;
      end else begin
         flush_seen <= flush_seen | flush;
         perr_seen <= perr_seen | perr;
      end
   end
   task complete_run;
      begin
         $display("errors %0d checks %0d", num_errors, n_tests);
         if (num_errors == 0 && n_tests > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      repeat (20000) @(posedge clock);
      num_errors = num_errors + 1;
      complete_run;
   end
   initial begin
      num_errors = 0;
      n_tests = 0;
      resetn = 1'b0;
      {sat_in, msg_done, msg_rx, msg_calc} = 16'h0000;
      repeat (16) @(posedge clock);
      resetn <= 1'b1;
      repeat (4) @(posedge clock);
      `check("supply", 4'h0, sup)
      `check("thresh", 12'h000, thr)
      `check("sense", 2'b00, {s4, s3})
      // global first; global aimed at channel four is refused
      host_u.frame({16'h1500, 16'h43E5, 16'h60DA, 16'h1500}, 4'h0);
      repeat (10) @(posedge clock);
      `check("variant", 4'h5, pvar)
      `check("odd", 1'b0, podd)
      `check("supply", 4'h6, sup)
      `check("decoder", 4'h2, dec)
      `check("dlen", 8'h30, dlen)
      `check("btime", 8'h0C, btime)
      `check("hyst", 4'h4, hyst)
      `check("thresh", 12'h0A8, thr)
      `check("flush", 4'h4, flush_seen)
      msg_done <= 4'h3;
      msg_rx <= 4'h3;
      @(posedge clock);
      msg_done <= 4'h0;
      repeat (3) @(posedge clock);
      `check("perr", 4'h1, perr_seen)
      sat_in <= 4'hF;
      repeat (12) @(posedge clock);
      `check("filtered", 4'hF, sfil)
      // masked write, bad parity word, plain channel length
      host_u.frame({16'h1500, 16'h5C3F, 16'h4000, 16'h4107}, 4'h2);
      repeat (10) @(posedge clock);
      `check("odd", 1'b1, podd)
      `check("rmode", 8'h0C, rmode)
      `check("thresh", 12'hEA8, thr)
      `check("hyst", 4'h4, hyst)
      `check("supply", 4'h4, sup)
      `check("decoder", 4'h0, dec)
      `check("btime", 8'h4C, btime)
      `check("dlen", 8'h30, dlen)
      `check("cmd_error", 1'b1, cerr)
      `check("reply", 64'hC500C3E5C0DAE000, host_u.rx_r)
      // odd sense: ch1 agrees, ch2 plain ignored, ch3 disagrees
      msg_done <= 4'h7;
      msg_calc <= 4'h5;
      msg_rx <= 4'h6;
      @(posedge clock);
      msg_done <= 4'h0;
      repeat (3) @(posedge clock);
      `check("perr_odd", 4'h5, perr_seen)
      resetn <= 1'b0;
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      repeat (3) @(posedge clock);
      `check("variant", 4'h0, pvar)
      `check("thresh", 12'h000, thr)
      complete_run;
   end
endmodule // testbench
